// file: shared/adcc_pkg.sv
/*
 * Constants, field layouts and state record of the converter control
 * block. Assumes byte-wide register indices spaced one word apart.
 */
package adcc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IX_MAIN = 6'h00;
    localparam logic [5:0] IX_ACC = 6'h01;
    localparam logic [5:0] IX_REFCLK = 6'h02;
    localparam logic [5:0] IX_DELAY = 6'h03;
    localparam logic [5:0] IX_WIN = 6'h04;
    localparam logic [5:0] IX_SAMPLEN = 6'h05;
    localparam logic [5:0] IX_INSEL = 6'h06;
    localparam logic [5:0] IX_TRIG = 6'h08;
    localparam logic [5:0] IX_EVCTL = 6'h09;
    localparam logic [5:0] IX_IRQEN = 6'h0a;
    localparam logic [5:0] IX_IRQFL = 6'h0b;
    localparam logic [5:0] IX_HALT = 6'h0c;
    localparam logic [5:0] IX_SCR = 6'h0d;
    localparam logic [5:0] IX_RES = 6'h10;
    localparam logic [5:0] IX_WLT = 6'h12;
    localparam logic [5:0] IX_WHT = 6'h14;
    localparam logic [5:0] IX_TRIM = 6'h16;

    // Field positions
    localparam int MC_EN = 0;
    localparam int MC_CONT = 1;
    localparam int MC_RES8 = 2;
    localparam int MC_SBRUN = 7;
    localparam int RC_CAP = 6;
    localparam int RC_REF = 4;
    localparam int FL_DONE = 0;
    localparam int FL_WIN = 1;

    // Writable bit masks; other bits read as zero
    localparam logic [7:0] MSK_MAIN = 8'h87;
    localparam logic [7:0] MSK_ACC = 8'h07;
    localparam logic [7:0] MSK_REFCLK = 8'h77;
    localparam logic [7:0] MSK_WIN = 8'h07;
    localparam logic [7:0] MSK_5B = 8'h1f;
    localparam logic [7:0] MSK_1B = 8'h01;
    localparam logic [7:0] MSK_2B = 8'h03;

    // Reset values
    localparam logic [7:0] RST8 = 8'h00;
    localparam logic [15:0] RST16 = 16'h0000;

    // Accumulation and window codes
    localparam logic [2:0] ACC_NONE = 3'h0;
    localparam logic [2:0] ACC_RSVD = 3'h7;
    localparam logic [2:0] WM_BELOW = 3'h1;
    localparam logic [2:0] WM_ABOVE = 3'h2;
    localparam logic [2:0] WM_INSIDE = 3'h3;
    localparam logic [2:0] WM_OUTSIDE = 3'h4;

    // Reference select codes
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_EXTPIN = 2'h2;

    localparam logic [1:0] AXI_OKAY = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } adcc_st_t;

    // Controls toward the analog sampling core
    typedef struct packed {
        logic en;
        logic start;
        logic [1:0] ref_sel;
        logic cap_reduced;
        logic [4:0] input_sel;
    } adcc_core_ctl_t;

    typedef struct packed {
        adcc_st_t st;
        logic [7:0] main_control;
        logic [7:0] accumulation_control;
        logic [7:0] reference_clock_control;
        logic [7:0] delay_control;
        logic [7:0] window_mode_control;
        logic [7:0] sampling_length_control;
        logic [7:0] input_select;
        logic [7:0] event_input_control;
        logic [7:0] irq_enable;
        logic [7:0] irq_flag_status;
        logic [7:0] halt_behaviour_control;
        logic [7:0] scratch_byte;
        logic [7:0] sampling_duty_trim;
        logic [15:0] window_low_threshold;
        logic [15:0] window_high_threshold;
        logic [15:0] conversion_value;
        logic [15:0] acc;
        logic [6:0] cnt;
        logic ev_q;
        logic [7:0] divc;
        logic adc_clk;
        logic core_en;
        logic core_start;
        logic result_evt;
        logic irq;
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [15:0] rdata;
        logic aw_have;
        logic w_have;
        logic [5:0] awidx;
        logic [15:0] wdata;
        logic [1:0] wstrb;
    } adcc_state_t;

endpackage : adcc_pkg

// file: hdl/adcc_ctrl.sv
/*
 * Converter control block: AXI4-Lite register file, conversion
 * sequencer with accumulation, window compare, interrupt and the
 * converter clock divider. Assumes the sampling core runs on aclk,
 * answers each start with one core_done pulse carrying core_data,
 * and that standby, halt and event inputs are synchronous to aclk.
 */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps

// Functional notes
// [R01] Enable bit gates all conversion activity
// [R02] standby_run keeps converter alive in standby
// [R03] resolution_select drops two low bits
// [R04] Continuous mode restarts after each completion
// [R05] Each completed cycle sets conversion_done_flag
// [R06] accum_count_select decodes to 1..64 samples
// [R07] Accumulated sum is one complete conversion
// [R08] reference_select drives core reference choice
// [R09] Converter clock is aclk over 2^(p+1)
// [R10] sample_cap_select drives reduced capacitance
// [R11] Registers sit at their printed offsets
// [R12] start_conversion_bit reads one while busy
// [R13] window_match cleared by write-one or result read
// [R14] window_mode_select chooses the compare condition
// [R15] Result-ready event is one-cycle pulse
// [R16] Reserved bits and addresses read zero
module adcc_ctrl
    import adcc_pkg::*;
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Sampling core
    output adcc_core_ctl_t core_ctl,
    output logic adc_clk,
    input wire logic core_done,
    input wire logic [9:0] core_data,
    // System conditions and events
    input wire logic standby,
    input wire logic dbg_halt,
    input wire logic ev_start_in,
    output logic result_event,
    output logic irq
);

    adcc_state_t s_reg;
    adcc_state_t s_next;

    ////////////////////////////////////////////////////////////////
    // Helper functions

    // Number of samples per complete conversion
    function automatic logic [6:0] acc_target(input logic [2:0] sel);
        logic [6:0] t;
        t = 7'h01;
        // [R06] sample count decode
        if (sel != ACC_NONE && sel != ACC_RSVD) begin
            t = 7'h01 << sel;
        end
        return t;
    endfunction : acc_target

    // Window compare on a finished result
    function automatic logic win_hit(
        input logic [2:0] mode,
        input logic [15:0] v,
        input logic [15:0] lt,
        input logic [15:0] ht
    );
        logic h;
        h = 1'b0;
        // [R14] compare mode decode
        case (mode)
            WM_BELOW: h = (v < lt);
            WM_ABOVE: h = (v > ht);
            WM_INSIDE: h = (v > lt) && (v < ht);
            WM_OUTSIDE: h = (v < lt) || (v > ht);
            default: h = 1'b0;
        endcase
        return h;
    endfunction : win_hit

    // Register read mux
    function automatic logic [15:0] rd_mux(
        input adcc_state_t s,
        input logic [5:0] idx
    );
        logic [15:0] r;
        r = 16'h0000;
        // [R11] printed offset map
        // [R16] unmapped reads zero
        case (idx)
            IX_MAIN: r = {8'h00, s.main_control};
            IX_ACC: r = {8'h00, s.accumulation_control};
            IX_REFCLK: r = {8'h00, s.reference_clock_control};
            IX_DELAY: r = {8'h00, s.delay_control};
            IX_WIN: r = {8'h00, s.window_mode_control};
            IX_SAMPLEN: r = {8'h00, s.sampling_length_control};
            IX_INSEL: r = {8'h00, s.input_select};
            // [R12] busy reads back
            IX_TRIG: r = {15'h0000, s.st == ST_BUSY};
            IX_EVCTL: r = {8'h00, s.event_input_control};
            IX_IRQEN: r = {8'h00, s.irq_enable};
            IX_IRQFL: r = {8'h00, s.irq_flag_status};
            IX_HALT: r = {8'h00, s.halt_behaviour_control};
            IX_SCR: r = {8'h00, s.scratch_byte};
            IX_RES: r = s.conversion_value;
            IX_WLT: r = s.window_low_threshold;
            IX_WHT: r = s.window_high_threshold;
            IX_TRIM: r = {8'h00, s.sampling_duty_trim};
            default: r = 16'h0000;
        endcase
        return r;
    endfunction : rd_mux

    ////////////////////////////////////////////////////////////////
    // Next-state logic

    // Everything is computed from s_reg into s_next
    always_comb begin
        logic start_req;
        logic active;
        logic [1:0] fl_clr;
        logic [1:0] fl_set;
        logic [15:0] smp;
        logic [15:0] sum;
        logic [6:0] cnt1;
        logic [7:0] lo;
        logic [7:0] hi;
        start_req = 1'b0;
        active = 1'b0;
        fl_clr = 2'b00;
        fl_set = 2'b00;
        smp = 16'h0000;
        sum = 16'h0000;
        cnt1 = 7'h00;
        lo = s_reg.wdata[7:0];
        hi = s_reg.wdata[15:8];
        s_next = s_reg;
        s_next.core_start = 1'b0;
        s_next.result_evt = 1'b0;

        // Read channel: one read in flight, answer next edge
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_mux(s_reg, araddr[7:2]);
            // [R13] result read clears
            if (araddr[7:2] == IX_RES) begin
                fl_clr[FL_WIN] = 1'b1;
            end
        end
        s_next.arready = !s_next.rvalid;

        // Write address and data are captured in either order
        if (awvalid && s_reg.awready) begin
            s_next.aw_have = 1'b1;
            s_next.awidx = awaddr[7:2];
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_have = 1'b1;
            s_next.wdata = wdata[15:0];
            s_next.wstrb = wstrb[1:0];
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // Register write once both halves are held
        if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            if (s_reg.wstrb[0]) begin
                // [R16] masked writable bits
                case (s_reg.awidx)
                    IX_MAIN: s_next.main_control = lo & MSK_MAIN;
                    IX_ACC: s_next.accumulation_control = lo & MSK_ACC;
                    IX_REFCLK: s_next.reference_clock_control = lo & MSK_REFCLK;
                    IX_DELAY: s_next.delay_control = lo;
                    IX_WIN: s_next.window_mode_control = lo & MSK_WIN;
                    IX_SAMPLEN: s_next.sampling_length_control = lo & MSK_5B;
                    IX_INSEL: s_next.input_select = lo & MSK_5B;
                    IX_TRIG: start_req = lo[0];
                    IX_EVCTL: s_next.event_input_control = lo & MSK_1B;
                    IX_IRQEN: s_next.irq_enable = lo & MSK_2B;
                    // [R13] write-one clears
                    IX_IRQFL: fl_clr = lo[1:0];
                    IX_HALT: s_next.halt_behaviour_control = lo & MSK_1B;
                    IX_SCR: s_next.scratch_byte = lo;
                    IX_WLT: s_next.window_low_threshold[7:0] = lo;
                    IX_WHT: s_next.window_high_threshold[7:0] = lo;
                    IX_TRIM: s_next.sampling_duty_trim = lo & MSK_1B;
                    default: ;
                endcase
            end
            if (s_reg.wstrb[1]) begin
                // High bytes exist only on the thresholds
                if (s_reg.awidx == IX_WLT) begin
                    s_next.window_low_threshold[15:8] = hi;
                end
                if (s_reg.awidx == IX_WHT) begin
                    s_next.window_high_threshold[15:8] = hi;
                end
            end
        end
        s_next.awready = !s_next.aw_have && !s_next.bvalid;
        s_next.wready = !s_next.w_have && !s_next.bvalid;

        // Rising edge of the event input also starts a conversion
        s_next.ev_q = ev_start_in;
        if (s_reg.event_input_control[0] && ev_start_in && !s_reg.ev_q) begin
            start_req = 1'b1;
        end

        // [R01] enable gating
        // [R02] standby survival
        active = s_reg.main_control[MC_EN]
            && (!standby || s_reg.main_control[MC_SBRUN])
            && (!dbg_halt || s_reg.halt_behaviour_control[0]);
        s_next.core_en = active;

        // Sequencer
        unique case (s_reg.st)
            ST_IDLE: begin
                if (active && start_req) begin
                    s_next.st = ST_BUSY;
                    s_next.acc = RST16;
                    s_next.cnt = 7'h00;
                    s_next.core_start = 1'b1;
                end
            end
            ST_BUSY: begin
                // Losing enable aborts; no partial result is stored
                if (!active) begin
                    s_next.st = ST_IDLE;
                end else if (core_done) begin
                    // [R03] truncate to eight bits
                    if (s_reg.main_control[MC_RES8]) begin
                        smp = {8'h00, core_data[9:2]};
                    end else begin
                        smp = {6'h00, core_data};
                    end
                    sum = s_reg.acc + smp;
                    cnt1 = s_reg.cnt + 7'h01;
                    // [R07] full set completes
                    if (cnt1 == acc_target(s_reg.accumulation_control[2:0])) begin
                        s_next.conversion_value = sum;
                        // [R05] done flag
                        fl_set[FL_DONE] = 1'b1;
                        // [R15] one-cycle event
                        s_next.result_evt = 1'b1;
                        if (win_hit(s_reg.window_mode_control[2:0], sum,
                                    s_reg.window_low_threshold,
                                    s_reg.window_high_threshold)) begin
                            fl_set[FL_WIN] = 1'b1;
                        end
                        s_next.acc = RST16;
                        s_next.cnt = 7'h00;
                        // [R04] continuous restart
                        if (s_reg.main_control[MC_CONT]) begin
                            s_next.core_start = 1'b1;
                        end else begin
                            // [R12] auto clear
                            s_next.st = ST_IDLE;
                        end
                    end else begin
                        s_next.acc = sum;
                        s_next.cnt = cnt1;
                        s_next.core_start = 1'b1;
                    end
                end
            end
        endcase

        // Hardware set wins over a clear in the same cycle
        s_next.irq_flag_status[1:0] = (s_reg.irq_flag_status[1:0] & ~fl_clr) | fl_set;
        s_next.irq = |(s_next.irq_flag_status[1:0] & s_next.irq_enable[1:0]);

        // [R09] power-of-two divider
        if (s_reg.main_control[MC_EN]) begin
            s_next.divc = s_reg.divc + 8'h01;
        end else begin
            s_next.divc = 8'h00;
        end
        s_next.adc_clk = s_next.divc[s_reg.reference_clock_control[2:0]];
    end

    ////////////////////////////////////////////////////////////////
    // State register

    // Clock enable freezes every bit, including the bus handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs, all taken from state bits or constants

    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = AXI_OKAY;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = {16'h0000, s_reg.rdata};
    assign rresp = AXI_OKAY;

    // Core controls
    assign core_ctl.en = s_reg.core_en;
    assign core_ctl.start = s_reg.core_start;
    // [R08] reference choice
    assign core_ctl.ref_sel = s_reg.reference_clock_control[RC_REF +: 2];
    // [R10] capacitance choice
    assign core_ctl.cap_reduced = s_reg.reference_clock_control[RC_CAP];
    assign core_ctl.input_sel = s_reg.input_select[4:0];

    assign adc_clk = s_reg.adc_clk;
    assign result_event = s_reg.result_evt;
    assign irq = s_reg.irq;

endmodule : adcc_ctrl

// file: dv/adcc_core_model.sv
/*
 * Behavioural sampling core: one done pulse per start after a latency
 * set by the bench. Assumes starts arrive on aclk.
 */
`timescale 1ns/100ps
module adcc_core_model
    import adcc_pkg::*;
(
    // Clock and controls from the block
    input wire logic aclk,
    input wire adcc_core_ctl_t core_ctl,
    // Sample value and latency, latency at least one
    input wire logic [9:0] sample,
    input wire logic [3:0] lat,
    // Answer
    output logic core_done,
    output logic [9:0] core_data
);
    logic [3:0] cnt;

    initial begin
        cnt = 4'h0;
        core_done = 1'b0;
        core_data = 10'h000;
    end

    // Disabling drops a sample in flight, like the real core
    always @(posedge aclk) begin
        core_done <= 1'b0;
        core_data <= ~core_data; // Data means nothing beside done low
        if (!core_ctl.en) begin
            cnt <= 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                core_done <= 1'b1;
                core_data <= sample;
            end
        end else if (core_ctl.start) begin
            cnt <= lat;
        end
    end
endmodule : adcc_core_model

// file: dv/adcc_ctrl_sva.sv
/*
 * Port checks of the converter control block.
 * Assumes ce held high; bound to every instance of the block.
 */
`timescale 1ns/100ps
module adcc_ctrl_sva
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // Core side
    input wire adcc_core_ctl_t core_ctl,
    input wire logic core_done,
    input wire logic result_event
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write not answered");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    a_read_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_resp_okay: assert property (bvalid |-> bresp == AXI_OKAY)
        else $error("bad write response");
    a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_start_enabled: assert property (core_ctl.start |-> core_ctl.en)
        else $error("start while disabled");
    a_start_pulse: assert property (core_ctl.start |=> !core_ctl.start)
        else $error("start too long");
    a_event_pulse: assert property (result_event |=> !result_event)
        else $error("event too long");
    a_event_cause: assert property (result_event |-> $past(core_done))
        else $error("event without sample");
endmodule : adcc_ctrl_sva

bind adcc_ctrl adcc_ctrl_sva chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .core_ctl(core_ctl), .core_done(core_done), .result_event(result_event));

// file: dv/adcc_ctrl_tb.sv
/*
 * Self-checking bench: register map, accumulation, window, interrupt,
 * free running, divider, standby. Assumes the core model beside it.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module adcc_ctrl_tb;
    import adcc_pkg::*;
    // Bench drives
    logic aclk = 1'b0, aresetn = 1'b0, standby = 1'b0, hlt = 1'b0, ev = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hf, lat = 4'ha;
    logic [9:0] smp = 10'h000;
    // Block answers
    logic awready, wready, bvalid, arready, rvalid, adc_clk, core_done, result_event, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] core_data;
    adcc_core_ctl_t core_ctl;
    int errors = 0, checks = 0;

    always #12.5 aclk = ~aclk;

    adcc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .core_ctl(core_ctl),
        .adc_clk(adc_clk), .core_done(core_done), .core_data(core_data),
        .standby(standby), .dbg_halt(hlt), .ev_start_in(ev),
        .result_event(result_event), .irq(irq));
    adcc_core_model core (.aclk(aclk), .core_ctl(core_ctl), .sample(smp), .lat(lat),
        .core_done(core_done), .core_data(core_data));

    ////////////////////////////////////////
    // Bus tasks start on an edge so no signal is driven twice in a step
    task automatic wr(input logic [5:0] ix, input logic [15:0] d);
        @(posedge aclk);
        awaddr <= {ix, 2'b00};
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] ix, output logic [31:0] d);
        @(posedge aclk);
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask : rd

    task automatic wait_ev;
        do @(posedge aclk); while (!result_event);
    endtask : wait_ev

    task automatic count_ev(output int n);
        n = 0;
        repeat (30) begin
            @(posedge aclk);
            // An unknown event level counts, so it cannot slip through
            if (result_event !== 1'b0) n++;
        end
    endtask : count_ev

    ////////////////////////////////////////
    task automatic t_regs;
        logic [5:0] ix [8] = '{IX_MAIN, IX_ACC, IX_REFCLK, IX_WIN, 6'h07, IX_SCR, IX_WHT, IX_RES};
        logic [15:0] ex [8] = '{16'h87, 16'h07, 16'h77, 16'h07, 16'h0, 16'hff, 16'hffff, 16'h0};
        logic [31:0] v;
        for (int i = 0; i < 8; i++) begin
            rd(ix[i], v);
            `CHK(v, 32'h0);
            `CHK(rresp, AXI_OKAY);
            wr(ix[i], 16'hffff);
            rd(ix[i], v);
            `CHK(v, {16'h0, ex[i]});
        end
        @(negedge aclk);
        `CHK(core_ctl.cap_reduced, 1'b1);
        wr(IX_INSEL, 16'hffff);
        @(negedge aclk);
        `CHK(core_ctl.input_sel, 5'h1f);
        for (int r = 0; r < 3; r++) begin
            wr(IX_REFCLK, 16'(r << 4));
            @(negedge aclk);
            `CHK({core_ctl.ref_sel, core_ctl.cap_reduced}, 3'(r << 1));
        end
        wr(IX_MAIN, 16'h0000);
        @(negedge aclk);
        `CHK(core_ctl.en, 1'b0);
    endtask : t_regs

    // Every accumulation code, half of them in eight-bit mode
    task automatic t_acc;
        logic [31:0] v;
        int n;
        smp <= 10'h2d7;
        wr(IX_IRQEN, 16'h0001);
        for (int c = 0; c < 8; c++) begin
            n = (c == 0 || c == 7) ? 1 : (1 << c);
            wr(IX_MAIN, {13'h0, c[0], 2'b01});
            wr(IX_ACC, 16'(c));
            wr(IX_TRIG, 16'h0001);
            rd(IX_TRIG, v);
            `CHK(v[0], 1'b1);
            wait_ev;
            rd(IX_RES, v);
            `CHK(v, 32'(n * (c[0] ? 16'h00b5 : 16'h02d7)));
            rd(IX_TRIG, v);
            `CHK(v[0], 1'b0);
            `CHK(irq, 1'b1);
            wr(IX_IRQFL, 16'h0001);
            @(negedge aclk);
            `CHK(irq, 1'b0);
        end
    endtask : t_acc

    // Each mode against inside, below and on-threshold samples
    task automatic t_win;
        logic [9:0] s [3] = '{10'h150, 10'h050, 10'h100};
        logic [31:0] v;
        logic [2:0] md;
        logic m;
        wr(IX_IRQEN, 16'h0000);
        wr(IX_MAIN, 16'h0001);
        wr(IX_ACC, 16'h0000);
        wr(IX_WLT, 16'h0100);
        wr(IX_WHT, 16'h0200);
        for (int k = 0; k < 24; k++) begin
            md = k[2:0];
            m = (k < 8) ? (md == 3'h3) : (k < 16) ? (md == 3'h1 || md == 3'h4) : 1'b0;
            smp <= s[k / 8];
            wr(IX_WIN, {13'h0, md});
            wr(IX_TRIG, 16'h0001);
            wait_ev;
            wr(IX_IRQFL, 16'h0000);
            rd(IX_IRQFL, v);
            `CHK(v[1:0], {m, 1'b1});
            `CHK(irq, 1'b0);
            if (k[0]) rd(IX_RES, v);
            else wr(IX_IRQFL, 16'h0002);
            wr(IX_IRQFL, 16'h0001);
            rd(IX_IRQFL, v);
            `CHK(v[1:0], 2'b00);
        end
    endtask : t_win

    // Prompt core, so the restart gap is three cycles
    task automatic t_free;
        logic [31:0] v;
        int n;
        lat <= 4'h1;
        wr(IX_MAIN, 16'h0003);
        wr(IX_TRIG, 16'h0001);
        repeat (3) wait_ev;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!result_event);
        `CHK(n, 3);
        wr(IX_MAIN, 16'h0000);
        rd(IX_TRIG, v);
        `CHK(v[0], 1'b0);
        count_ev(n);
        `CHK(n, 0);
        lat <= 4'ha;
    endtask : t_free

    task automatic t_div;
        int n;
        wr(IX_MAIN, 16'h0001);
        for (int p = 0; p < 8; p++) begin
            wr(IX_REFCLK, 16'(p));
            do @(posedge aclk); while (adc_clk);
            do @(posedge aclk); while (!adc_clk);
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (adc_clk);
            do begin
                @(posedge aclk);
                n++;
            end while (!adc_clk);
            `CHK(n, 2 << p);
        end
    endtask : t_div

    // Standby and debug halt gate starts; an event edge starts one conversion
    task automatic t_stby;
        int n;
        standby <= 1'b1;
        wr(IX_TRIG, 16'h0001);
        count_ev(n);
        `CHK(n, 0);
        wr(IX_MAIN, 16'h0081);
        wr(IX_TRIG, 16'h0001);
        count_ev(n);
        `CHK(n, 1);
        wr(IX_EVCTL, 16'h0001);
        ev <= 1'b1;
        count_ev(n);
        `CHK(n, 1);
        ev <= 1'b0;
        hlt <= 1'b1;
        wr(IX_TRIG, 16'h0001);
        count_ev(n);
        `CHK(n, 0);
        wr(IX_HALT, 16'h0001);
        wr(IX_TRIG, 16'h0001);
        count_ev(n);
        `CHK(n, 1);
        hlt <= 1'b0;
        standby <= 1'b0;
    endtask : t_stby

    ////////////////////////////////////////
    task end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_acc;
        t_win;
        t_free;
        t_div;
        t_stby;
        end_sim;
    end

    // Whole run needs near 4000 cycles; ten times that means a hang
    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        end_sim;
    end
endmodule : adcc_ctrl_tb
